//--- src/usu_defines.svh
// Summary of operation
// R01 - One 8-bit shift register, CPU accessible, with a separate buffer copy
// R02 - Shift register top bit reaches data-out through a latch on the opposite edge
// R03 - Serial input is always taken from the data-in pin
// R04 - 4-bit readable and writable counter whose overflow can request an interrupt
// R05 - Shift register and counter advance from the same selected clock
// R06 - External clock makes the counter count both edges
// R07 - Clock source is the clock pin, timer 0 match or software strobe
// R08 - Two-wire start condition can request an interrupt
// R09 - Clock pin held low after a start condition or counter overflow
// R10 - Three-wire operation is SPI mode 0 or 1, no slave select
// R11 - Eight clock cycles exchange the shift registers of two units
// R12 - Clock pin level is set by port output writes and toggled by the clock-toggle strobe
// R13 - Edge select 0: sample on rising edge, change output on falling edge
// R14 - Edge select 1: sample on falling edge, change output on rising edge
// R15 - Each party loads data and enables driver half a period before sampling
// R16 - Software clears the counter before each byte
// R17 - Sixteen counted edges overflow the counter and set the overflow flag
// R18 - Overflow interrupt can wake the processor from idle sleep
// R19 - Without the buffer, software reads the byte before the next transfer
// R20 - Status write with flag one and counter zero clears flag and counter
// R21 - Software strobe clock: each strobe advances counter and toggles clock pin
// R22 - Alternating strobe writes shift one bit per pair, up to half CPU clock
// R23 - Wire mode at control bits 5:4 changes output pin behaviour and enables start detection in two-wire modes
// R24 - Control bit 6 enables the overflow interrupt, gated by global enable
// R25 - Buffer register takes the shift register at each counter overflow
// R26 - Reset clears shift register, buffer, counter, flags and controls
`ifndef USU_DEFINES_SVH
`define USU_DEFINES_SVH
`define USU_CR_START_IE 7
`define USU_CR_OVF_IE 6
`define USU_CR_WM_HI 5
`define USU_CR_WM_LO 4
`define USU_CR_SRC_SEL 3
`define USU_CR_EDGE_SEL 2
`define USU_CR_SHIFT_STB 1
`define USU_CR_TOGGLE_STB 0
`define USU_SR_START_FLAG 7
`define USU_SR_OVF_FLAG 6
`define USU_SR_CNT_HI 3
`define USU_SR_CNT_LO 0
`define USU_BYTE_RST 8'h00
`define USU_CNT_RST 4'h0
`define USU_CNT_MAX 4'hf
`define USU_CNT_ONE 4'h1
`define USU_FIFO_DEPTH 16
`define USU_FIFO_AW 4
`endif

//--- src/usu_pkg.sv
`include "usu_defines.svh"
package usu_pkg;
  typedef logic [7:0] usu_byte_t;
  typedef logic [3:0] usu_cnt_t;
  typedef enum logic [1:0] {
    USU_WM_OFF = 2'h0,
    USU_WM_THREE = 2'h1,
    USU_WM_TWO = 2'h2,
    USU_WM_TWO_HOLD = 2'h3
  } usu_wire_mode_e;
endpackage

//--- src/usu_sync.sv
`timescale 1ns/1ps
`default_nettype none
module usu_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule // usu_sync
`default_nettype wire

//--- src/usu_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module usu_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;
  always_comb begin
    in_ready_o = (wr_q - rd_q) != (AW+1)'(DEPTH);
    out_valid_o = wr_q != rd_q;
    push = in_valid_i & in_ready_o;
    pop = out_valid_o & out_ready_i;
    wr_d = wr_q + (AW+1)'(push);
    rd_d = rd_q + (AW+1)'(pop);
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end
  // Storage has no reset; only the pointers say what is valid
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
  assign out_data_o = mem_q[rd_q[AW-1:0]];
endmodule // usu_fifo
`default_nettype wire

//--- src/usu_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "usu_defines.svh"
module usu_core
  import usu_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control register write and readback
  input wire logic ctrl_wr_i,
  input wire logic [7:0] ctrl_wdata_i,
  output logic [7:0] ctrl_o,
  // Status register write and readback
  input wire logic stat_wr_i,
  input wire logic [7:0] stat_wdata_i,
  output logic [7:0] stat_o,
  // Shift data register and buffer
  input wire logic data_wr_i,
  input wire logic [7:0] data_wdata_i,
  output logic [7:0] data_o,
  output logic [7:0] buffer_o,
  // Port bits of the clock pin and direction bits of the data pins
  input wire logic port_out_wr_i,
  input wire logic port_out_sck_i,
  input wire logic port_dir_sck_i,
  input wire logic port_dir_do_i,
  input wire logic port_dir_di_i,
  // Timer 0 compare match pulse and global interrupt enable
  input wire logic timer_match_i,
  input wire logic global_ie_i,
  // Interrupt requests
  output logic ovf_irq_o,
  output logic start_irq_o,
  // Serial clock pin
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  // Serial data in pin, open drain data line in two-wire mode
  input wire logic di_i,
  output logic di_o,
  output logic di_oe_o,
  // Serial data out pin
  output logic do_o,
  output logic do_oe_o,
  // Received byte stream
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  output logic rx_space_o
);
  logic [1:0] pins_s;
  logic sck_s, di_s;
  logic sck_p_q, sck_p_d, di_p_q, di_p_d;
  usu_byte_t data_q, data_d, buf_q, buf_d;
  usu_cnt_t cnt_q, cnt_d;
  logic [7:2] ctrl_q, ctrl_d;
  logic ovf_q, ovf_d, start_q, start_d;
  logic do_q, do_d, sck_lvl_q, sck_lvl_d;
  logic edge_sel, src_sel, start_ie, ovf_ie;
  logic cnt_by_tgl_q, cnt_by_tgl_d, cnt_by_tgl;
  usu_wire_mode_e wm;
  logic rise, fall, sample_edge, sw_shift, sw_toggle;
  logic shift_tick, cnt_tick, cnt_wrap, start_det, hold_low;

  // Pins pass two flops; both share one synchroniser so they stay aligned
  usu_sync #(
    .W(2)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({sck_i, di_i}),
    .sync_o(pins_s)
  );
  assign sck_s = pins_s[1];
  assign di_s = pins_s[0];

  // Edge, source and count settings of a control write act in the same cycle as its strobes
  always_comb begin
    edge_sel = ctrl_wr_i ? ctrl_wdata_i[`USU_CR_EDGE_SEL] : ctrl_q[`USU_CR_EDGE_SEL];
    src_sel = ctrl_wr_i ? ctrl_wdata_i[`USU_CR_SRC_SEL] : ctrl_q[`USU_CR_SRC_SEL];
    // Shift strobe bit is kept: with the pin source it hands counting to the toggle strobe
    cnt_by_tgl = ctrl_wr_i ? ctrl_wdata_i[`USU_CR_SHIFT_STB] : cnt_by_tgl_q;
    start_ie = ctrl_q[`USU_CR_START_IE];
    ovf_ie = ctrl_q[`USU_CR_OVF_IE];
    wm = usu_wire_mode_e'(ctrl_q[`USU_CR_WM_HI:`USU_CR_WM_LO]); // see R23
  end

  // Clock source selection and tick generation
  always_comb begin
    rise = sck_s & ~sck_p_q;
    fall = ~sck_s & sck_p_q;
    sw_shift = ctrl_wr_i & ctrl_wdata_i[`USU_CR_SHIFT_STB];
    sw_toggle = ctrl_wr_i & ctrl_wdata_i[`USU_CR_TOGGLE_STB];
    sample_edge = edge_sel ? fall : rise; // see R13 see R14
    // External pin, else timer match or software strobe
    if (src_sel) begin // see R07
      shift_tick = sample_edge;
    end else if (edge_sel) begin
      shift_tick = timer_match_i;
    end else begin
      shift_tick = sw_shift;
    end
    // Pin clock counts both edges unless counting is handed to the toggle strobe
    if (src_sel) begin
      cnt_tick = cnt_by_tgl ? sw_toggle : (rise | fall); // see R06 see R21
    end else begin
      cnt_tick = shift_tick; // see R05
    end
    cnt_wrap = cnt_tick & (cnt_q == `USU_CNT_MAX); // see R17
    start_det = wm[1] & sck_s & di_p_q & ~di_s; // see R08
    hold_low = (wm == USU_WM_TWO_HOLD & ovf_q) | (wm[1] & start_q); // see R09
  end

  // Shift register, buffer and output latch
  always_comb begin
    data_d = data_q;
    buf_d = buf_q;
    do_d = do_q;
    sck_p_d = sck_s;
    di_p_d = di_s;
    if (data_wr_i) begin
      data_d = data_wdata_i; // see R01
    end else if (shift_tick) begin
      data_d = {data_q[6:0], di_s}; // see R03 see R11
    end
    if (cnt_wrap) begin
      buf_d = data_d; // see R25
    end
    // Latch is open in the half period opposite to sampling
    if (sck_s == edge_sel) begin
      do_d = data_q[7]; // see R02 see R10
    end
  end

  // Counter, flags, control bits and clock pin level
  always_comb begin
    cnt_d = cnt_q;
    ovf_d = ovf_q;
    start_d = start_q;
    ctrl_d = ctrl_q;
    sck_lvl_d = sck_lvl_q;
    cnt_by_tgl_d = cnt_by_tgl;
    if (ctrl_wr_i) begin
      ctrl_d = ctrl_wdata_i[7:2];
    end
    if (stat_wr_i) begin
      cnt_d = stat_wdata_i[`USU_SR_CNT_HI:`USU_SR_CNT_LO]; // see R04 see R20
      if (stat_wdata_i[`USU_SR_OVF_FLAG]) begin
        ovf_d = 1'b0; // see R20
      end
      if (stat_wdata_i[`USU_SR_START_FLAG]) begin
        start_d = 1'b0;
      end
    end else if (cnt_tick) begin
      cnt_d = cnt_q + `USU_CNT_ONE; // see R04
    end
    // A new event wins over a clear in the same cycle
    if (cnt_wrap) begin
      ovf_d = 1'b1; // see R17
    end
    if (start_det) begin
      start_d = 1'b1;
    end
    if (port_out_wr_i) begin
      sck_lvl_d = port_out_sck_i; // see R12
    end else if (sw_toggle) begin
      sck_lvl_d = ~sck_lvl_q; // see R12 see R21 see R22
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin // see R26
      data_q <= `USU_BYTE_RST;
      buf_q <= `USU_BYTE_RST;
      cnt_q <= `USU_CNT_RST;
      ctrl_q <= '0;
      ovf_q <= 1'b0;
      start_q <= 1'b0;
      do_q <= 1'b0;
      sck_lvl_q <= 1'b0;
      cnt_by_tgl_q <= 1'b0;
      sck_p_q <= 1'b0;
      di_p_q <= 1'b0;
    end else begin
      data_q <= data_d;
      buf_q <= buf_d;
      cnt_q <= cnt_d;
      ctrl_q <= ctrl_d;
      ovf_q <= ovf_d;
      start_q <= start_d;
      do_q <= do_d;
      sck_lvl_q <= sck_lvl_d;
      cnt_by_tgl_q <= cnt_by_tgl_d;
      sck_p_q <= sck_p_d;
      di_p_q <= di_p_d;
    end
  end

  // Received bytes queue up for a reader; a full queue drops further bytes
  // but the buffer register still keeps the newest one
  usu_fifo #(
    .W(8),
    .DEPTH(`USU_FIFO_DEPTH),
    .AW(`USU_FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(cnt_wrap),
    .in_ready_o(rx_space_o),
    .in_data_i(data_d),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_data_o)
  );

  // Readback, pins and interrupts
  always_comb begin
    ctrl_o = {ctrl_q, 2'h0};
    stat_o = {start_q, ovf_q, 2'h0, cnt_q};
    data_o = data_q;
    buffer_o = buf_q;
    ovf_irq_o = ovf_q & ovf_ie & global_ie_i; // see R24 see R18
    start_irq_o = start_q & start_ie & global_ie_i; // see R08
    // No slave select: the data driver follows only the wire mode and the direction bit
    do_o = do_q;
    do_oe_o = (wm == USU_WM_THREE) & port_dir_do_i; // see R10 see R23
    di_o = 1'b0;
    di_oe_o = wm[1] & port_dir_di_i & ~do_q;
    sck_o = hold_low ? 1'b0 : sck_lvl_q;
    sck_oe_o = hold_low | (port_dir_sck_i & wm[1] & ~sck_lvl_q) |
               (port_dir_sck_i & ~wm[1]);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_last_tick;
    cnt_tick && !stat_wr_i && cnt_q == 4'hf;
  endsequence
  sequence s_flag_up;
    ovf_q && cnt_q == 4'h0;
  endsequence

  property p_ovf_set;
    s_last_tick |=> s_flag_up;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set"); // see R17

  property p_buf_copy;
    s_last_tick |=> buf_q == $past(data_d);
  endproperty
  a_buf_copy: assert property (p_buf_copy) else $error("buffer not updated"); // see R25

  property p_clear;
    stat_wr_i && stat_wdata_i == 8'h40 && !cnt_wrap |=> !ovf_q && cnt_q == 4'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("status clear failed"); // see R20

  property p_count;
    cnt_tick && !stat_wr_i |=> cnt_q == $past(cnt_q) + 4'h1;
  endproperty
  a_count: assert property (p_count) else $error("counter did not advance"); // see R04

  property p_both_edges;
    src_sel && !cnt_by_tgl && !stat_wr_i && (rise || fall) |=> cnt_q != $past(cnt_q);
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("edge not counted"); // see R06

  property p_shift_in;
    shift_tick && !data_wr_i |=> data_q == {$past(data_q[6:0]), $past(di_s)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift lost di"); // see R03

  property p_mode0;
    src_sel && !edge_sel && !ctrl_wr_i && fall |-> !shift_tick;
  endproperty
  a_mode0: assert property (p_mode0) else $error("shifted on wrong edge"); // see R13

  property p_toggle;
    sw_toggle && !port_out_wr_i |=> sck_lvl_q != $past(sck_lvl_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("clock pin not toggled"); // see R12

  property p_irq;
    ovf_q && ovf_ie && global_ie_i |-> ovf_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("overflow request missing"); // see R24

  property p_do_stable;
    sck_s != edge_sel && !$changed(sck_s) |=> $stable(do_q);
  endproperty
  a_do_stable: assert property (p_do_stable) else $error("data out moved early"); // see R02

  sequence s_strobe_count;
    src_sel && cnt_by_tgl && !stat_wr_i;
  endsequence

  property p_pin_edge_ignored;
    s_strobe_count ##0 !sw_toggle |=> $stable(cnt_q);
  endproperty
  a_pin_edge_ignored: assert property (p_pin_edge_ignored) else $error("pin edge counted"); // see R21

  property p_toggle_count;
    s_strobe_count ##0 sw_toggle |=> cnt_q == $past(cnt_q) + 4'h1;
  endproperty
  a_toggle_count: assert property (p_toggle_count) else $error("toggle not counted"); // see R21

  property p_fifo_push;
    cnt_wrap && rx_space_o |=> rx_valid_o;
  endproperty
  a_fifo_push: assert property (p_fifo_push) else $error("byte not queued"); // see R25

  property p_hold;
    hold_low |-> !sck_o && sck_oe_o;
  endproperty
  a_hold: assert property (p_hold) else $error("clock pin not held low"); // see R09

  property p_do_off;
    wm != USU_WM_THREE |-> !do_oe_o;
  endproperty
  a_do_off: assert property (p_do_off) else $error("data out driven in wrong mode"); // see R23

  property p_start;
    start_det |=> start_q;
  endproperty
  a_start: assert property (p_start) else $error("start flag not set"); // see R08

  property p_mode1;
    src_sel && edge_sel && !ctrl_wr_i && rise |-> !shift_tick;
  endproperty
  a_mode1: assert property (p_mode1) else $error("shifted on rising edge"); // see R14

  property p_data_load;
    data_wr_i |=> data_q == $past(data_wdata_i);
  endproperty
  a_data_load: assert property (p_data_load) else $error("data write lost"); // see R01

  property p_timer;
    !src_sel && edge_sel && timer_match_i |-> shift_tick && cnt_tick;
  endproperty
  a_timer: assert property (p_timer) else $error("timer match ignored"); // see R07

  property p_soft;
    !src_sel && !edge_sel && sw_shift |-> shift_tick && cnt_tick;
  endproperty
  a_soft: assert property (p_soft) else $error("shift strobe ignored"); // see R05
endmodule // usu_core
`default_nettype wire

//--- tb/usu_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module usu_peer_model (
  // Link
  input wire logic sck_line_i,
  input wire logic dev_bit_i,
  output logic sck_o,
  output logic data_to_dev_o,
  // Setup and result
  input wire logic edge1_i,
  output logic [7:0] rx_o
);
  logic [7:0] sr_q;
  logic out_q;
  initial begin
    sck_o = 1'b0;
    sr_q = 8'h00;
    out_q = 1'b0;
  end
  assign data_to_dev_o = out_q;
  assign rx_o = sr_q;
  // Byte and first bit are ready well before the first sampling edge
  task automatic load(input logic [7:0] b);
    sr_q = b;
    out_q = b[7];
  endtask
  // Clock stands low between frames
  task automatic run_byte();
    repeat (16) begin
      #160;
      sck_o = ~sck_o;
    end
  endtask
  always @(posedge sck_line_i) begin
    if (!edge1_i) sr_q <= {sr_q[6:0], dev_bit_i};
    else out_q <= sr_q[7];
  end
  always @(negedge sck_line_i) begin
    if (edge1_i) sr_q <= {sr_q[6:0], dev_bit_i};
    else out_q <= sr_q[7];
  end
endmodule // usu_peer_model
`default_nettype wire

//--- tb/universal_serial_shifter_three_wire_tb.sv
`timescale 1ns/1ps
`default_nettype none
module universal_serial_shifter_three_wire_tb
  import usu_pkg::*;
;
  logic clk_i, rst_i, ctrl_wr_i, stat_wr_i, data_wr_i, port_out_wr_i, port_out_sck_i;
  logic timer_match_i, global_ie_i, rx_ready_i, pm, e1, psck, pdat;
  logic [7:0] ctrl_wdata_i, stat_wdata_i, data_wdata_i, ctrl_o, stat_o, data_o, buffer_o;
  logic [7:0] rx_data_o, prx;
  logic sck_o, do_o, ovf_irq_o, rx_valid_o, rx_space_o;
  logic [31:0] rng;
  int err_total, samples_checked, n;
  usu_byte_t exp_q[$];
  usu_byte_t d, p;
  usu_core u_usu_core (.clk_i(clk_i), .rst_i(rst_i), .ctrl_wr_i(ctrl_wr_i),
    .ctrl_wdata_i(ctrl_wdata_i), .ctrl_o(ctrl_o), .stat_wr_i(stat_wr_i),
    .stat_wdata_i(stat_wdata_i), .stat_o(stat_o), .data_wr_i(data_wr_i),
    .data_wdata_i(data_wdata_i), .data_o(data_o), .buffer_o(buffer_o),
    .port_out_wr_i(port_out_wr_i), .port_out_sck_i(port_out_sck_i), .port_dir_sck_i(1'b1),
    .port_dir_do_i(1'b1), .port_dir_di_i(1'b0), .timer_match_i(timer_match_i),
    .global_ie_i(global_ie_i), .ovf_irq_o(ovf_irq_o), .start_irq_o(), .sck_i(pm ? psck : sck_o),
    .sck_o(sck_o), .sck_oe_o(), .di_i(pdat), .di_o(), .di_oe_o(), .do_o(do_o), .do_oe_o(),
    .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o),
    .rx_space_o(rx_space_o));
  usu_peer_model u_usu_peer_model (.sck_line_i(pm ? psck : sck_o), .dev_bit_i(do_o),
    .sck_o(psck), .data_to_dev_o(pdat), .edge1_i(e1), .rx_o(prx));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction
  // Received bytes leave the FIFO in push order
  always @(posedge clk_i) begin
    if (!rst_i && rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
      if (exp_q.size() == 0) chk(rx_data_o, 8'hxx);
      else chk(rx_data_o, exp_q.pop_front());
    end
  end
  // One write strobe per call; the strobe drops a cycle later so calls never collide
  task automatic wr(input int k, input logic [7:0] v);
    @(negedge clk_i);
    {ctrl_wr_i, stat_wr_i, data_wr_i} = 3'b100 >> k;
    {ctrl_wdata_i, stat_wdata_i, data_wdata_i} = {3{v}};
    @(negedge clk_i);
    {ctrl_wr_i, stat_wr_i, data_wr_i} = 3'b000;
  endtask
  task automatic setup(input logic [7:0] sv);
    d = rnd();
    p = rnd();
    u_usu_peer_model.load(p);
    wr(2, d);
    wr(1, sv);
  endtask
  // Spacing leaves room for the pin synchronizer between strobes
  task automatic mst(input logic [7:0] a, input logic [7:0] b, input logic [7:0] es);
    pm = 1'b0;
    e1 = 1'b0;
    setup(8'h40);
    if (es[6]) exp_q.push_back(p);
    repeat (8) begin
      wr(0, a);
      repeat (4) @(negedge clk_i);
      wr(0, b);
      repeat (4) @(negedge clk_i);
    end
    chk(data_o, p);
    chk(prx, d);
    chk(stat_o, es);
  endtask
  task automatic slv(input logic m1);
    pm = 1'b1;
    e1 = m1;
    setup(8'h40);
    exp_q.push_back(p);
    wr(0, {5'b00011, m1, 2'b00});
    repeat (2) @(negedge clk_i);
    u_usu_peer_model.run_byte();
    repeat (6) @(negedge clk_i);
    chk(data_o, p);
    chk(prx, d);
    chk(stat_o, 8'h40);
    chk(buffer_o, p);
  endtask
  // Counter preset to 12 so four timer events complete a frame
  task automatic tmr(input logic push);
    pm = 1'b0;
    setup(8'h4c);
    if (push) exp_q.push_back({d[3:0], {4{p[7]}}});
    repeat (4) begin
      @(negedge clk_i);
      timer_match_i = 1'b1;
      @(negedge clk_i);
      timer_match_i = 1'b0;
    end
    @(negedge clk_i);
    chk(stat_o, 8'h40);
    chk(buffer_o, {d[3:0], {4{p[7]}}});
    chk({7'h00, ovf_irq_o}, 8'h01);
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    $display("[ERR] %0t run did not finish", $time);
    give_verdict();
  end
  initial begin
    {rst_i, global_ie_i, rx_ready_i} = 3'b111;
    {ctrl_wr_i, stat_wr_i, data_wr_i, port_out_wr_i, port_out_sck_i, timer_match_i} = 6'h00;
    {ctrl_wdata_i, stat_wdata_i, data_wdata_i} = 24'h000000;
    {pm, e1} = 2'b00;
    rng = 32'd76;
    err_total = 0;
    samples_checked = 0;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    chk(ctrl_o, 8'h00);
    chk(stat_o, 8'h00);
    chk(data_o, 8'h00);
    chk(buffer_o, 8'h00);
    chk({6'h00, rx_valid_o, rx_space_o}, 8'h01);
    for (n = 0; n < 2; n++) begin
      port_out_sck_i = ~n[0];
      port_out_wr_i = 1'b1;
      @(negedge clk_i);
      port_out_wr_i = 1'b0;
      @(negedge clk_i);
      chk({7'h00, sck_o}, {7'h00, ~n[0]});
    end
    mst(8'h1b, 8'h1b, 8'h40);
    chk(ctrl_o, 8'h18);
    mst(8'h11, 8'h13, 8'h08);
    slv(1'b0);
    slv(1'b1);
    wr(0, 8'h54);
    tmr(1'b1);
    global_ie_i = 1'b0;
    @(negedge clk_i);
    chk({7'h00, ovf_irq_o}, 8'h00);
    global_ie_i = 1'b1;
    rx_ready_i = 1'b0;
    repeat (16) tmr(1'b1);
    chk({7'h00, rx_space_o}, 8'h00);
    tmr(1'b0);
    rx_ready_i = 1'b1;
    for (n = 0; n < 40 && rx_valid_o !== 1'b0; n++) @(negedge clk_i);
    chk({7'h00, rx_valid_o}, 8'h00);
    chk(8'(exp_q.size()), 8'h00);
    give_verdict();
  end
endmodule // universal_serial_shifter_three_wire_tb
`default_nettype wire
